//--- verilog/bpm_pkg.sv
/*
  Shared constants and carrier types for the Bluetooth pad function mux:
  pad indices, pad function codes and the bundles that pass between the
  Bluetooth core and the pad ring.
  Assumes a single core clock and that pad buffers resolve out/oe pairs.
*/
package bpm_pkg;

  // ------------------------------------------------------------------
  // pad indices
  // ------------------------------------------------------------------
  localparam int NUM_PADS = 19;
  localparam int GPIO_W = 8;
  localparam int FUNC_W = 4;

  localparam int PAD_UART_CTS = 0;
  localparam int PAD_UART_RTS = 1;
  localparam int PAD_UART_RXD = 2;
  localparam int PAD_UART_TXD = 3;
  localparam int PAD_PCM_IN = 4;
  localparam int PAD_PCM_OUT = 5;
  localparam int PAD_PCM_SYNC = 6;
  localparam int PAD_PCM_CLK = 7;
  localparam int PAD_I2S_DO = 8;
  localparam int PAD_I2S_DI = 9;
  localparam int PAD_I2S_WS = 10;
  localparam int PAD_I2S_CLK = 11;
  localparam int PAD_GPIO5 = 12;
  localparam int PAD_GPIO4 = 13;
  localparam int PAD_GPIO3 = 14;
  localparam int PAD_GPIO2 = 15;
  localparam int PAD_GPIO1 = 16;
  localparam int PAD_GPIO0 = 17;
  localparam int PAD_CLK_REQ = 18;

  // ------------------------------------------------------------------
  // pad function codes
  // ------------------------------------------------------------------
  localparam logic [3:0] FN_0 = 4'h0;
  localparam logic [3:0] FN_1 = 4'h1;
  localparam logic [3:0] FN_2 = 4'h2;
  localparam logic [3:0] FN_3 = 4'h3;
  localparam logic [3:0] FN_4 = 4'h4;
  localparam logic [3:0] FN_5 = 4'h5;
  localparam logic [3:0] FN_7 = 4'h7;
  localparam logic [3:0] FN_15 = 4'hF;

  localparam logic RST_LOW = 1'b0;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  // signals the core drives toward the pads
  typedef struct packed {
    logic uart_rts_n;
    logic uart_txd;
    logic pcm_out;
    logic pcm_master;
    logic pcm_sync_out;
    logic pcm_clk_out;
    logic i2s_master_data;
    logic i2s_master_wordsel;
    logic i2s_master_bitclk;
    logic i2s_slave_data;
    logic bt_priority;
    logic coex_radio_busy;
    logic radio_link_indicator;
    logic clk_req;
    logic host_clk;
    logic low_power_osc_out;
    logic audio_clk;
    logic class1_ctrl;
    logic flash_serial_clock;
    logic flash_select_n;
    logic flash_data_out;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe;
    logic [7:0] agpio_out;
    logic [7:0] agpio_oe;
  } bpm_core_out_t;

  // signals sampled from the pads for the core
  typedef struct packed {
    logic uart_cts_n;
    logic uart_rxd;
    logic pcm_in;
    logic pcm_sync_in;
    logic pcm_clk_in;
    logic i2s_data_in;
    logic i2s_slave_bitclk;
    logic i2s_slave_wordsel;
    logic coex_tx_grant;
    logic flash_data_in;
    logic [7:0] gpio_in;
    logic [7:0] agpio_in;
  } bpm_core_in_t;

  // one pad's drive
  typedef struct packed {
    logic out;
    logic oe;
  } bpm_pad_drv_t;

endpackage

//--- verilog/bpm_pad_mux.sv
/*
  Per-pad function multiplexer for the Bluetooth multipurpose pads.
  Each pad has its own 4-bit function select; the mux routes core signals
  out to the pads with matching output enables and gathers pad levels
  back into the core input bundle.
  Assumes all pad inputs and selects are synchronous to i_clk.
*/
// Overview of operation
// (RULE1) each pad is software-chosen GPIO or function
// (RULE2) per-pad select, codes 0..7 and 15
// (RULE3) pad selects are fully independent
// (RULE4) select zero means plain general-purpose I/O, except UART on the UART pads and clk_req on CLK_REQ
// (RULE5) second GPIO group via PCM/I2S pads
// (RULE6) PCM sync driven as master, sampled otherwise
// (RULE7) PCM clock driven as master, sampled otherwise
// (RULE8) coex busy pad high during BT slots
// (RULE9) partner drives tx grant; pad input only
// (RULE10) flash mode drives SPI serial clock
// (RULE11) flash mode drives select low-active
// (RULE12) flash drives data-in line device samples
// (RULE13) UART RTS driven as pad output
// (RULE14) clock request driven as device output
// (RULE15) oe follows function; unassigned means input
`timescale 1ns/1ps

module bpm_pad_mux #(
  parameter int NPADS = bpm_pkg::NUM_PADS
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [NPADS*bpm_pkg::FUNC_W-1:0] i_pad_func,
  input wire bpm_pkg::bpm_core_out_t i_core,
  output bpm_pkg::bpm_core_in_t o_core,
  input wire logic [NPADS-1:0] i_pad_in,
  output logic [NPADS-1:0] o_pad_out,
  output logic [NPADS-1:0] o_pad_oe
);
  import bpm_pkg::*;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // each pad decodes only its own select field
  function automatic logic [3:0] fn_of(input int p,
      input logic [NPADS*FUNC_W-1:0] f);
    fn_of = f[p*FUNC_W +: FUNC_W]; // RULE3
  endfunction

  function automatic bpm_pad_drv_t drv(input logic v, input logic e);
    drv.out = v;
    drv.oe = e;
  endfunction

  // output side of one pad; default leaves the pad as an input
  function automatic bpm_pad_drv_t pad_drive(input int p,
      input logic [3:0] f, input bpm_core_out_t c);
    bpm_pad_drv_t d;
    d = drv(1'b0, 1'b0); // RULE15
    case (p)
      PAD_UART_CTS: begin
        if (f == FN_7) d = drv(c.agpio_out[1], c.agpio_oe[1]); // RULE5
      end
      PAD_UART_RTS: begin
        if (f == FN_0) d = drv(c.uart_rts_n, 1'b1); // RULE13
        else if (f == FN_7) d = drv(c.agpio_out[0], c.agpio_oe[0]);
      end
      PAD_UART_RXD: begin
        if (f == FN_7) d = drv(c.gpio_out[5], c.gpio_oe[5]);
      end
      PAD_UART_TXD: begin
        if (f == FN_0) d = drv(c.uart_txd, 1'b1);
        else if (f == FN_7) d = drv(c.gpio_out[4], c.gpio_oe[4]);
      end
      PAD_PCM_IN: begin
        if (f == FN_0) d = drv(c.agpio_out[3], c.agpio_oe[3]); // RULE5
        else if (f == FN_3) d = drv(c.host_clk, 1'b1);
      end
      PAD_PCM_OUT: begin
        case (f)
          FN_0: d = drv(c.agpio_out[2], c.agpio_oe[2]); // RULE5
          FN_1, FN_2: d = drv(c.pcm_out, 1'b1);
          FN_3: d = drv(c.radio_link_indicator, 1'b1);
          FN_5: d = drv(c.i2s_master_data, 1'b1);
          FN_7: d = drv(c.i2s_slave_data, 1'b1);
          FN_15: d = drv(c.flash_data_out, 1'b1);
          default: d = drv(1'b0, 1'b0);
        endcase
      end
      PAD_PCM_SYNC: begin
        case (f)
          FN_0: d = drv(c.agpio_out[1], c.agpio_oe[1]);
          FN_1, FN_2: d = drv(c.pcm_sync_out, c.pcm_master); // RULE6
          FN_3: d = drv(c.host_clk, 1'b1);
          FN_4: d = drv(c.low_power_osc_out, 1'b1);
          FN_5: d = drv(c.i2s_master_wordsel, 1'b1);
          FN_15: d = drv(c.flash_select_n, 1'b1); // RULE11
          default: d = drv(1'b0, 1'b0);
        endcase
      end
      PAD_PCM_CLK: begin
        case (f)
          FN_0: d = drv(c.agpio_out[0], c.agpio_oe[0]);
          FN_1, FN_2: d = drv(c.pcm_clk_out, c.pcm_master); // RULE7
          FN_5: d = drv(c.i2s_master_bitclk, 1'b1);
          FN_15: d = drv(c.flash_serial_clock, 1'b1); // RULE10
          default: d = drv(1'b0, 1'b0);
        endcase
      end
      PAD_I2S_DO: begin
        case (f)
          FN_0: d = drv(c.agpio_out[5], c.agpio_oe[5]);
          FN_1: d = drv(c.pcm_out, 1'b1);
          FN_4: d = drv(c.i2s_slave_data, 1'b1);
          FN_5: d = drv(c.i2s_master_data, 1'b1);
          FN_7: d = drv(c.bt_priority, 1'b1);
          default: d = drv(1'b0, 1'b0);
        endcase
      end
      PAD_I2S_DI: begin
        // grant function stays an input: oe low
        if (f == FN_0) d = drv(c.agpio_out[6], c.agpio_oe[6]);
        else if (f == FN_3) d = drv(c.host_clk, 1'b1); // RULE9
      end
      PAD_I2S_WS: begin
        case (f)
          FN_0: d = drv(c.gpio_out[7], c.gpio_oe[7]);
          FN_1: d = drv(c.pcm_sync_out, c.pcm_master); // RULE6
          FN_3: d = drv(c.radio_link_indicator, 1'b1);
          FN_5: d = drv(c.i2s_master_wordsel, 1'b1);
          default: d = drv(1'b0, 1'b0);
        endcase
      end
      PAD_I2S_CLK: begin
        case (f)
          FN_0: d = drv(c.gpio_out[6], c.gpio_oe[6]);
          FN_1: d = drv(c.pcm_clk_out, c.pcm_master); // RULE7
          FN_4: d = drv(c.low_power_osc_out, 1'b1);
          FN_5: d = drv(c.i2s_master_bitclk, 1'b1);
          default: d = drv(1'b0, 1'b0);
        endcase
      end
      PAD_GPIO5: begin
        case (f)
          FN_0: d = drv(c.gpio_out[5], c.gpio_oe[5]); // RULE4
          FN_1: d = drv(c.host_clk, 1'b1);
          FN_3: d = drv(c.i2s_master_bitclk, 1'b1);
          FN_7: d = drv(c.clk_req, 1'b1); // RULE14
          default: d = drv(1'b0, 1'b0);
        endcase
      end
      PAD_GPIO4: begin
        case (f)
          FN_0: d = drv(c.gpio_out[4], c.gpio_oe[4]); // RULE4
          FN_1: d = drv(c.radio_link_indicator, 1'b1);
          FN_3: d = drv(c.i2s_master_data, 1'b1);
          FN_4: d = drv(c.i2s_slave_data, 1'b1);
          default: d = drv(1'b0, 1'b0);
        endcase
      end
      PAD_GPIO3: begin
        if (f == FN_0) d = drv(c.gpio_out[3], c.gpio_oe[3]); // RULE4
        else if (f == FN_3) d = drv(c.i2s_master_wordsel, 1'b1);
      end
      PAD_GPIO2: begin
        if (f == FN_0) d = drv(c.gpio_out[2], c.gpio_oe[2]); // RULE4
      end
      PAD_GPIO1: begin
        if (f == FN_0) d = drv(c.gpio_out[1], c.gpio_oe[1]); // RULE4
        else if (f == FN_7) d = drv(c.class1_ctrl, 1'b1);
      end
      PAD_GPIO0: begin
        case (f)
          FN_0: d = drv(c.gpio_out[0], c.gpio_oe[0]); // RULE4
          FN_4: d = drv(c.audio_clk, 1'b1);
          FN_7: d = drv(c.coex_radio_busy, 1'b1); // RULE8
          default: d = drv(1'b0, 1'b0);
        endcase
      end
      PAD_CLK_REQ: begin
        if (f == FN_0) d = drv(c.clk_req, 1'b1); // RULE14
        else if (f == FN_7) d = drv(c.agpio_out[7], c.agpio_oe[7]);
      end
      default: d = drv(1'b0, 1'b0);
    endcase
    pad_drive = d;
  endfunction

  // ------------------------------------------------------------------
  // output path
  // ------------------------------------------------------------------
  logic [NPADS-1:0] pad_out_nxt;
  logic [NPADS-1:0] pad_oe_nxt;
  logic [NPADS-1:0] pad_out_r;
  logic [NPADS-1:0] pad_oe_r;

  // one decoder per pad, each keyed only by its own select
  for (genvar g = 0; g < NPADS; g++) begin : g_pad
    wire bpm_pad_drv_t d_w = pad_drive(g, fn_of(g, i_pad_func), i_core);
    assign pad_out_nxt[g] = d_w.out; // RULE1 RULE2
    assign pad_oe_nxt[g] = d_w.oe; // RULE15
  end

  // registered so pads never see decoder glitches on a select change
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pad_out_r <= '0;
      pad_oe_r <= '0;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
    end
  end

  assign o_pad_out = pad_out_r;
  assign o_pad_oe = pad_oe_r;

  // ------------------------------------------------------------------
  // input path
  // ------------------------------------------------------------------
  // a pad contributes only while its select names that function;
  // several pads on one function are ORed, so avoid such setups
  function automatic logic hit(input int p, input logic [3:0] f);
    hit = (fn_of(p, i_pad_func) == f) & i_pad_in[p];
  endfunction

  function automatic logic sel(input int p, input logic [3:0] f);
    sel = (fn_of(p, i_pad_func) == f);
  endfunction

  bpm_core_in_t in_nxt;
  bpm_core_in_t in_r;

  // a process, not assigns: hit and sel read the pad ports directly,
  // and only a process keeps such reads in its sensitivity
  always_comb begin
    in_nxt = '0;
    // idle-high UART inputs read high when no pad carries them
    in_nxt.uart_cts_n = ~sel(PAD_UART_CTS, FN_0) |
        i_pad_in[PAD_UART_CTS];
    in_nxt.uart_rxd = ~sel(PAD_UART_RXD, FN_0) |
        i_pad_in[PAD_UART_RXD];
    in_nxt.pcm_in = hit(PAD_PCM_IN, FN_1) | hit(PAD_PCM_IN, FN_2) |
        hit(PAD_I2S_DI, FN_1);
    // sampled only while an external master drives them
    in_nxt.pcm_sync_in = ~i_core.pcm_master &
        (hit(PAD_PCM_SYNC, FN_1) | hit(PAD_PCM_SYNC, FN_2) |
         hit(PAD_I2S_WS, FN_1)); // RULE6
    in_nxt.pcm_clk_in = ~i_core.pcm_master &
        (hit(PAD_PCM_CLK, FN_1) | hit(PAD_PCM_CLK, FN_2) |
         hit(PAD_I2S_CLK, FN_1)); // RULE7
    in_nxt.i2s_data_in = hit(PAD_PCM_IN, FN_7) |
        hit(PAD_I2S_DI, FN_4) | hit(PAD_GPIO2, FN_4);
    in_nxt.i2s_slave_bitclk = hit(PAD_PCM_CLK, FN_7) |
        hit(PAD_I2S_CLK, FN_7) | hit(PAD_GPIO5, FN_4);
    in_nxt.i2s_slave_wordsel = hit(PAD_PCM_SYNC, FN_7) |
        hit(PAD_I2S_WS, FN_7) | hit(PAD_GPIO3, FN_4);
    in_nxt.coex_tx_grant = hit(PAD_I2S_DI, FN_7); // RULE9
    in_nxt.flash_data_in = hit(PAD_PCM_IN, FN_15); // RULE12
    in_nxt.gpio_in = {
        hit(PAD_I2S_WS, FN_0), hit(PAD_I2S_CLK, FN_0),
        hit(PAD_GPIO5, FN_0) | hit(PAD_UART_RXD, FN_7),
        hit(PAD_GPIO4, FN_0) | hit(PAD_UART_TXD, FN_7),
        hit(PAD_GPIO3, FN_0), hit(PAD_GPIO2, FN_0),
        hit(PAD_GPIO1, FN_0), hit(PAD_GPIO0, FN_0)}; // RULE4
    in_nxt.agpio_in = {
        hit(PAD_CLK_REQ, FN_7), hit(PAD_I2S_DI, FN_0),
        hit(PAD_I2S_DO, FN_0), RST_LOW,
        hit(PAD_PCM_IN, FN_0), hit(PAD_PCM_OUT, FN_0),
        hit(PAD_PCM_SYNC, FN_0) | hit(PAD_UART_CTS, FN_7),
        hit(PAD_PCM_CLK, FN_0) | hit(PAD_UART_RTS, FN_7)}; // RULE5
  end

  // one register stage toward the core, matching the output path
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) in_r <= '0;
    else in_r <= in_nxt;
  end

  assign o_core = in_r;

endmodule

//--- sim/bpm_pad_mux_monitor.sv
/*
  Concurrent checks on the pad mux ports: function to pad routing,
  direction per function and the one-cycle registered answer.
  Assumes one clock and the asynchronous active-high reset.
*/
`timescale 1ns/1ps
module bpm_pad_mux_checker
  import bpm_pkg::*;
#(
  parameter int NPADS = bpm_pkg::NUM_PADS
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [NPADS*bpm_pkg::FUNC_W-1:0] i_pad_func,
  input wire bpm_pkg::bpm_core_out_t i_core,
  input wire bpm_pkg::bpm_core_in_t o_core,
  input wire logic [NPADS-1:0] i_pad_in,
  input wire logic [NPADS-1:0] o_pad_out,
  input wire logic [NPADS-1:0] o_pad_oe
);
  // ----------------------------------------------------------------
  // helper: skip the first edge after reset, $past still sees reset
  // ----------------------------------------------------------------
  logic live_r;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) live_r <= 1'b0;
    else live_r <= 1'b1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_rts_out_drive: assert property (
    live_r && $past(i_pad_func[7:4]) == 4'h0 |->
    o_pad_oe[1] && o_pad_out[1] == $past(i_core.uart_rts_n))
    else $error("rts pad not driven from core");
  a_sync_dir: assert property (
    live_r && $past(i_pad_func[27:24]) == 4'h1 |->
    o_pad_oe[6] == $past(i_core.pcm_master))
    else $error("pcm sync direction wrong");
  a_pcm_clk_dir: assert property (
    live_r && $past(i_pad_func[31:28]) == 4'h2 |->
    o_pad_oe[7] == $past(i_core.pcm_master))
    else $error("pcm clock direction wrong");
  a_flash_clk_out: assert property (
    live_r && $past(i_pad_func[31:28]) == 4'hF |->
    o_pad_oe[7] && o_pad_out[7] == $past(i_core.flash_serial_clock))
    else $error("flash clock not driven");
  a_flash_sel_out: assert property (
    live_r && $past(i_pad_func[27:24]) == 4'hF |->
    o_pad_oe[6] && o_pad_out[6] == $past(i_core.flash_select_n))
    else $error("flash select not driven");
  a_flash_din: assert property (
    live_r && $past(i_pad_func[19:16]) == 4'hF |->
    !o_pad_oe[4] && o_core.flash_data_in == $past(i_pad_in[4]))
    else $error("flash data in not sampled");
  a_coex_busy_out: assert property (
    live_r && $past(i_pad_func[71:68]) == 4'h7 |->
    o_pad_oe[17] && o_pad_out[17] == $past(i_core.coex_radio_busy))
    else $error("coex busy pad wrong");
  a_grant_in: assert property (
    live_r && $past(i_pad_func[39:36]) == 4'h7 |->
    !o_pad_oe[9] && o_core.coex_tx_grant == $past(i_pad_in[9]))
    else $error("tx grant pad wrong");
  a_unused_idle: assert property (
    live_r && $past(i_pad_func[27:24]) inside {4'h6, [4'h8:4'hE]} |->
    !o_pad_oe[6] && !o_pad_out[6])
    else $error("unassigned code drives pad");
  a_clk_req_out: assert property (
    live_r && $past(i_pad_func[75:72]) == 4'h0 |->
    o_pad_oe[18] && o_pad_out[18] == $past(i_core.clk_req))
    else $error("clock request not driven");
endmodule

bind bpm_pad_mux bpm_pad_mux_checker #(.NPADS(NPADS)) u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_pad_func(i_pad_func),
  .i_core(i_core), .o_core(o_core), .i_pad_in(i_pad_in),
  .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe));

//--- sim/bpm_far_side.sv
/*
  Far side of the pads: pcm master, serial flash, coex partner.
  Assumes the bench picks which pads the outside drives.
*/
`timescale 1ns/1ps
module bpm_far_side (
  input wire logic i_clk,
  input wire logic [18:0] i_pad_out,
  input wire logic [18:0] i_pad_oe,
  input wire logic [18:0] i_ext_drv,
  input wire logic [18:0] i_ext_val,
  input wire logic i_flash_bit,
  output logic [18:0] o_pad_in
);
  logic flip_r = 1'b0;
  logic flash_on;
  // undriven lines wander so a stale level is never trusted
  always_ff @(posedge i_clk) flip_r <= ~flip_r;
  // flash answers only while selected low
  assign flash_on = i_pad_oe[6] && !i_pad_out[6];
  // resolve each wire: device, flash, outside party, else floating
  always_comb begin
    for (int p = 0; p < 19; p++) begin
      if (i_pad_oe[p]) o_pad_in[p] = i_pad_out[p];
      else if (p == 4 && flash_on) o_pad_in[p] = i_flash_bit;
      else if (i_ext_drv[p]) o_pad_in[p] = i_ext_val[p];
      else o_pad_in[p] = flip_r;
    end
  end
endmodule

//--- sim/testbench.sv
/*
  Self-checking bench for the pad mux; one task per scenario.
  Assumes the one-cycle registered answer; inputs change at negedge.
*/
`timescale 1ns/1ps
module testbench;
  import bpm_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [75:0] func = '0;
  bpm_core_out_t core = '0;
  bpm_core_in_t o_core;
  logic [18:0] pad_in, pad_out, pad_oe;
  logic [18:0] ext_drv = '0;
  logic [18:0] ext_val = '0;
  logic flash_bit = 1'b0;
  int fails = 0;
  int check_count = 0;
  always #10 i_clk = ~i_clk;
  bpm_pad_mux dut (.i_clk(i_clk), .i_reset(i_reset), .i_pad_func(func),
    .i_core(core), .o_core(o_core), .i_pad_in(pad_in),
    .o_pad_out(pad_out), .o_pad_oe(pad_oe));
  bpm_far_side far (.i_clk(i_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe),
    .i_ext_drv(ext_drv), .i_ext_val(ext_val), .i_flash_bit(flash_bit),
    .o_pad_in(pad_in));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_gpio();
    func = '0;
    core.gpio_out = 8'hA5;
    core.gpio_oe = 8'hFF;
    core.uart_rts_n = 1'b1;
    core.clk_req = 1'b1;
    tick(1);
    chk({pad_oe[17:10], pad_out[17:10]}, 16'hFFA5);
    chk({pad_oe[18], pad_out[18]}, 2'b11);
    chk({pad_oe[1], pad_out[1]}, 2'b11);
    core.gpio_oe = 8'h00;
    ext_drv[17:10] = 8'hFF;
    ext_val[17:10] = 8'h0F;
    tick(2);
    chk({pad_oe[17:10], o_core.gpio_in}, 16'h00F0);
    ext_drv = '0;
    $display("test gpio done");
  endtask
  task automatic t_agpio();
    func[7:4] = 4'h7;
    core.agpio_out = 8'h6A;
    core.agpio_oe = 8'hFF;
    core.uart_txd = 1'b1;
    tick(1);
    chk({pad_oe[9:4], pad_out[9:4]}, 12'hFF5);
    chk({pad_out[3], pad_out[1], pad_oe[1]}, 3'b101);
    core.agpio_oe = 8'h00;
    ext_drv[9:0] = 10'h3F7;
    ext_val[9:0] = 10'h352;
    tick(2);
    chk(o_core.agpio_in, 8'h6B);
    chk({o_core.uart_cts_n, o_core.uart_rxd}, 2'b00);
    ext_drv = '0;
    func = '0;
    $display("test agpio done");
  endtask
  task automatic t_pcm();
    func[27:24] = 4'h1;
    func[31:28] = 4'h2;
    core.pcm_master = 1'b1;
    core.pcm_sync_out = 1'b1;
    tick(1);
    chk({pad_oe[7:6], pad_out[7:6]}, 4'hD);
    core.pcm_master = 1'b0;
    tick(1);
    ext_drv[7:6] = 2'b11;
    ext_val[7:6] = 2'b10;
    tick(2);
    chk({pad_oe[7:6], o_core.pcm_clk_in, o_core.pcm_sync_in}, 4'h2);
    ext_val[7:6] = 2'b01;
    tick(1);
    chk({o_core.pcm_clk_in, o_core.pcm_sync_in}, 2'b01);
    ext_drv = '0;
    $display("test pcm done");
  endtask
  task automatic t_flash();
    func[31:16] = 16'hFFFF;
    core.flash_serial_clock = 1'b1;
    core.flash_select_n = 1'b0;
    flash_bit = 1'b1;
    tick(2);
    chk({pad_oe[7], pad_out[7]}, 2'b11);
    chk({pad_oe[6], pad_out[6]}, 2'b10);
    chk({pad_oe[4], o_core.flash_data_in}, 2'b01);
    flash_bit = 1'b0;
    tick(1);
    chk(o_core.flash_data_in, 1'b0);
    func = '0;
    $display("test flash done");
  endtask
  task automatic t_coex();
    func[71:68] = 4'h7;
    func[39:36] = 4'h7;
    core.coex_radio_busy = 1'b1;
    ext_drv[9] = 1'b1;
    ext_val[9] = 1'b1;
    tick(2);
    chk({pad_oe[17], pad_out[17]}, 2'b11);
    chk({pad_oe[9], o_core.coex_tx_grant}, 2'b01);
    core.coex_radio_busy = 1'b0;
    ext_val[9] = 1'b0;
    tick(1);
    chk({pad_out[17], o_core.coex_tx_grant}, 2'b00);
    func = '0;
    ext_drv = '0;
    $display("test coex done");
  endtask
  task automatic t_codes();
    logic [15:0] drives;
    drives = 16'h803F;
    core = '1;
    core.flash_select_n = 1'b1;
    for (int v = 0; v < 16; v++) begin
      func[27:24] = v[3:0];
      tick(1);
      chk(pad_oe[6], drives[v]);
      if (!drives[v]) chk(pad_out[6], 1'b0);
    end
    $display("test codes done");
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    tick(4);
    chk(pad_oe, '0);
    chk(pad_out, '0);
    chk(o_core, '0);
    i_reset = 1'b0;
    tick(2);
    t_gpio();
    t_agpio();
    t_pcm();
    t_flash();
    t_coex();
    t_codes();
    report_and_stop();
  end
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
endmodule
